//--- logic/switch_port_control_regs.v
// Port 1 control register bank and the per-frame decisions it steers
`timescale 1ns/1ps
`include "port_ctrl_defines.vh"
module switch_port_control_regs (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [7:0] reg_address,
   input wire reg_write,
   input wire reg_read,
   input wire [1:0] reg_byte_enable,
   input wire [15:0] reg_write_data,
   output reg [15:0] reg_read_data,
   output reg reg_read_valid,
   input wire autoneg_flow_control,
   output reg flow_control_enable,
   output reg back_pressure_enable,
   output reg sniffer_port,
   input wire rx_frame_valid,
   input wire rx_tagged,
   input wire [11:0] rx_vid,
   input wire [2:0] rx_priority,
   input wire [2:0] rx_vlan_members,
   input wire [2:0] rx_destination_ports,
   input wire rx_broadcast,
   input wire rx_multicast,
   input wire rx_flooded,
   input wire [11:0] rx_length,
   output reg rx_result_valid,
   output reg rx_accept,
   output reg rx_learn,
   output reg rx_monitor,
   output reg [11:0] rx_effective_vid,
   output reg [2:0] rx_priority_out,
   output reg [2:0] rx_forward_ports,
   output reg rx_rate_counted,
   output reg [11:0] rx_rate_bytes,
   input wire tx_frame_valid,
   input wire tx_was_tagged,
   input wire [1:0] tx_class,
   input wire [2:0] tx_source_port,
   input wire [11:0] tx_length,
   output reg tx_result_valid,
   output reg tx_allowed,
   output reg tx_insert_tag,
   output reg tx_remove_tag,
   output reg [15:0] tx_tag,
   output reg [1:0] tx_queue,
   output reg tx_monitor,
   output reg [11:0] tx_rate_bytes
);
   reg [15:0] control_one;
   reg [15:0] control_two;
   reg [15:0] default_tag;
   reg [15:0] control_three;
   reg [15:0] next_read_data;
   reg [2:0] next_prio;
   reg next_counted;
   reg next_accept;
   wire [2:0] membership;
   wire [1:0] limit_mode;
   wire [2:0] ceiling;
   wire [11:0] vid_default;

   // Merge a byte-enabled write, keeping only implemented bits
   function [15:0] merge;
      input [15:0] old;
      input [15:0] data;
      input [1:0] be;
      input [15:0] mask;
      reg [15:0] lanes;
      begin
         lanes = {{8{be[1]}}, {8{be[0]}}};
         merge = ((old & ~lanes) | (data & lanes)) & mask; // [R21]
      end
   endfunction

   // Bytes charged to the rate counters for one frame
   function [11:0] rate_bytes;
      input [11:0] len;
      input gap;
      input pre;
      begin
         rate_bytes = len + (gap ? `GAP_BYTES : 12'h000) // [R19]
            + (pre ? `PREAMBLE_BYTES : 12'h000); // [R20]
      end
   endfunction

   assign membership = control_two[2:0];
   assign limit_mode = control_three[`MSB_LIMIT_MODE:`LSB_LIMIT_MODE];
   assign ceiling = default_tag[15:13];
   assign vid_default = default_tag[11:0];

   // Register writes
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         control_one <= `RST_CONTROL_ONE;
         control_two <= `RST_CONTROL_TWO; // [R8] [R9]
         default_tag <= `RST_DEFAULT_TAG; // [R16]
         control_three <= `RST_CONTROL_THREE;
      end else if (ce && reg_write) begin
         case (reg_address)
            `OFS_CONTROL_ONE: begin
               control_one <= merge(control_one, reg_write_data, reg_byte_enable,
                  `MASK_CONTROL_ONE);
            end
            `OFS_CONTROL_TWO: begin
               control_two <= merge(control_two, reg_write_data, reg_byte_enable,
                  `MASK_CONTROL_TWO);
            end
            `OFS_DEFAULT_TAG: begin
               default_tag <= merge(default_tag, reg_write_data, reg_byte_enable,
                  `MASK_DEFAULT_TAG); // [R16]
            end
            `OFS_CONTROL_THREE: begin
               control_three <= merge(control_three, reg_write_data, reg_byte_enable,
                  `MASK_CONTROL_THREE);
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (reg_address)
         `OFS_CONTROL_ONE: next_read_data = control_one;
         `OFS_CONTROL_TWO: next_read_data = control_two;
         `OFS_DEFAULT_TAG: next_read_data = default_tag;
         `OFS_CONTROL_THREE: next_read_data = control_three;
         default: next_read_data = 16'h0000;
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_read_data <= 16'h0000;
         reg_read_valid <= 1'b0;
      end else if (ce) begin
         reg_read_valid <= reg_read;
         if (reg_read) begin
            reg_read_data <= next_read_data;
         end
      end
   end

   // Port level controls
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         flow_control_enable <= 1'b0;
         back_pressure_enable <= 1'b0;
         sniffer_port <= 1'b0;
      end else if (ce) begin
         flow_control_enable <= control_two[`BIT_FORCE_FLOW] | autoneg_flow_control; // [R6]
         back_pressure_enable <= control_two[`BIT_BACK_PRESSURE]; // [R7]
         sniffer_port <= control_two[`BIT_SNIFFER]; // [R11]
      end
   end

   // Ingress classification
   always @* begin
      next_accept = control_two[`BIT_RX_ENABLE]; // [R9]
      if (control_two[`BIT_VLAN_FILTER] && ((rx_vlan_members & `THIS_PORT) == 3'h0)) begin
         next_accept = 1'b0; // [R4]
      end
      if (control_two[`BIT_DROP_NON_DEFAULT] && rx_tagged && rx_vid != vid_default) begin
         next_accept = 1'b0; // [R5]
      end
      next_prio = rx_priority;
      if (control_two[`BIT_PRIO_CEILING] && rx_priority > ceiling) begin
         next_prio = ceiling; // [R14]
      end
      case (limit_mode) // [R18]
         `MODE_ALL: next_counted = 1'b1;
         `MODE_BC_MC_FLOOD: next_counted = rx_broadcast | rx_multicast | rx_flooded;
         `MODE_BC_MC: next_counted = rx_broadcast | rx_multicast;
         `MODE_BC: next_counted = rx_broadcast;
         default: next_counted = 1'b1;
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_result_valid <= 1'b0;
         rx_accept <= 1'b0;
         rx_learn <= 1'b0;
         rx_monitor <= 1'b0;
         rx_effective_vid <= 12'h000;
         rx_priority_out <= 3'h0;
         rx_forward_ports <= 3'h0;
         rx_rate_counted <= 1'b0;
         rx_rate_bytes <= 12'h000;
      end else if (ce) begin
         rx_result_valid <= rx_frame_valid;
         if (rx_frame_valid) begin
            rx_accept <= next_accept;
            rx_learn <= next_accept & ~control_two[`BIT_LEARN_DISABLE]; // [R10]
            rx_monitor <= next_accept & control_two[`BIT_RX_SNIFF]; // [R12]
            rx_effective_vid <= (!rx_tagged || rx_vid == 12'h000) ? vid_default
               : rx_vid; // [R17]
            rx_priority_out <= next_prio;
            rx_forward_ports <= next_accept ? (rx_destination_ports & membership)
               : 3'h0; // [R15]
            rx_rate_counted <= next_counted;
            rx_rate_bytes <= rate_bytes(rx_length, control_three[`BIT_COUNT_GAP],
               control_three[`BIT_COUNT_PREAMBLE]);
         end
      end
   end

   // Egress handling
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_result_valid <= 1'b0;
         tx_allowed <= 1'b0;
         tx_insert_tag <= 1'b0;
         tx_remove_tag <= 1'b0;
         tx_tag <= 16'h0000;
         tx_queue <= 2'h0;
         tx_monitor <= 1'b0;
         tx_rate_bytes <= 12'h000;
      end else if (ce) begin
         tx_result_valid <= tx_frame_valid;
         if (tx_frame_valid) begin
            tx_allowed <= control_two[`BIT_TX_ENABLE] // [R8]
               & ((tx_source_port & membership) != 3'h0); // [R15]
            tx_insert_tag <= control_one[`BIT_TAG_INSERT] & ~tx_was_tagged; // [R1]
            tx_remove_tag <= control_one[`BIT_TAG_REMOVE] & tx_was_tagged; // [R2]
            tx_tag <= default_tag; // [R17]
            tx_queue <= control_one[`BIT_MULTI_QUEUE] ? tx_class : 2'h0; // [R3]
            tx_monitor <= control_two[`BIT_TX_ENABLE] & control_two[`BIT_TX_SNIFF]; // [R13]
            tx_rate_bytes <= rate_bytes(tx_length, control_three[`BIT_COUNT_GAP],
               control_three[`BIT_COUNT_PREAMBLE]);
         end
      end
   end
endmodule

//--- logic/port_ctrl_defines.vh
// Offsets, field positions, reset values and byte counts of the port 1 control registers
// How it works
// R1 - Tag insertion: untagged frames get the ingress default tag on egress
// R2 - Tag removal: tagged frames lose their tag on egress, untagged untouched
// R3 - Multiple queues: four egress queues q0..q3, otherwise one queue
// R4 - Ingress VLAN filtering drops frames whose VLAN members exclude this port
// R5 - Discard non default VID: drop frames whose VID differs from default VID
// R6 - Force flow control overrides auto-negotiation; else negotiated result applies
// R7 - Half-duplex back pressure only while its enable bit is set
// R8 - Transmit only while transmit enable is set; resets to one
// R9 - Accept received frames only while receive enable is set; resets to one
// R10 - Learning disable stops source address learning from this port
// R11 - Sniffer bit makes this port the destination of monitored frames
// R12 - Receive sniff marks every accepted received frame monitored, copy to sniffer
// R13 - Transmit sniff marks every transmitted frame monitored, copy to sniffer
// R14 - Priority ceiling caps frame priority at default tag user priority
// R15 - Port exchanges frames only with ports in its three-bit membership
// R16 - Default tag: priority 15:13, CFI 12, VID 11:0 resetting to one
// R17 - Default VID used for untagged or null-VID ingress frames and lookup
// R18 - Ingress limit mode selects which frame classes are rate counted
// R19 - Gap count adds 12 bytes per frame to rate calculations
// R20 - Preamble count adds 8 bytes per frame to rate calculations
// R21 - Reserved bits read zero and writes to them have no effect
`ifndef PORT_CTRL_DEFINES_VH
`define PORT_CTRL_DEFINES_VH
`define OFS_CONTROL_ONE 8'h6c
`define OFS_CONTROL_TWO 8'h6e
`define OFS_DEFAULT_TAG 8'h70
`define OFS_CONTROL_THREE 8'h72
`define BIT_TAG_INSERT 2
`define BIT_TAG_REMOVE 1
`define BIT_MULTI_QUEUE 0
`define BIT_VLAN_FILTER 14
`define BIT_DROP_NON_DEFAULT 13
`define BIT_FORCE_FLOW 12
`define BIT_BACK_PRESSURE 11
`define BIT_TX_ENABLE 10
`define BIT_RX_ENABLE 9
`define BIT_LEARN_DISABLE 8
`define BIT_SNIFFER 7
`define BIT_RX_SNIFF 6
`define BIT_TX_SNIFF 5
`define BIT_PRIO_CEILING 3
`define MSB_LIMIT_MODE 3
`define LSB_LIMIT_MODE 2
`define BIT_COUNT_GAP 1
`define BIT_COUNT_PREAMBLE 0
`define MASK_CONTROL_ONE 16'h0007
`define MASK_CONTROL_TWO 16'h7fef
`define MASK_DEFAULT_TAG 16'hffff
`define MASK_CONTROL_THREE 16'h000f
`define RST_CONTROL_ONE 16'h0000
`define RST_CONTROL_TWO 16'h0607
`define RST_DEFAULT_TAG 16'h0001
`define RST_CONTROL_THREE 16'h0000
`define MODE_ALL 2'h0
`define MODE_BC_MC_FLOOD 2'h1
`define MODE_BC_MC 2'h2
`define MODE_BC 2'h3
`define GAP_BYTES 12'h00c
`define PREAMBLE_BYTES 12'h008
`define THIS_PORT 3'h1
`endif

//--- test/port_ctrl_checker.sv
// Concurrent checks on the port 1 control register bank
`timescale 1ns/1ps
module port_ctrl_checker (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire reg_read,
   input wire reg_read_valid,
   input wire autoneg_flow_control,
   input wire flow_control_enable,
   input wire rx_frame_valid,
   input wire [2:0] rx_priority,
   input wire rx_result_valid,
   input wire rx_accept,
   input wire rx_learn,
   input wire rx_monitor,
   input wire [2:0] rx_priority_out,
   input wire [2:0] rx_forward_ports,
   input wire tx_frame_valid,
   input wire tx_was_tagged,
   input wire tx_result_valid,
   input wire tx_insert_tag,
   input wire tx_remove_tag
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence rx_taken;
      ce && rx_frame_valid;
   endsequence
   sequence tx_taken;
      ce && tx_frame_valid;
   endsequence
   a_read_answer: assert property (ce |=> reg_read_valid == $past(reg_read))
      else $error("Read answer out of step");
   a_rx_answer: assert property (ce |=> rx_result_valid == $past(rx_frame_valid))
      else $error("Ingress answer out of step");
   a_tx_answer: assert property (ce |=> tx_result_valid == $past(tx_frame_valid))
      else $error("Egress answer out of step");
   a_flow_follow: assert property (ce && autoneg_flow_control |=> flow_control_enable)
      else $error("Flow control not enabled");
   a_drop_quiet: assert property (rx_result_valid && !rx_accept |->
      !rx_learn && !rx_monitor && rx_forward_ports == 3'h0) else $error("Dropped frame used");
   a_insert_untagged: assert property (tx_taken ##0 tx_was_tagged |=> !tx_insert_tag)
      else $error("Tag added to tagged frame");
   a_remove_tagged: assert property (tx_taken ##0 !tx_was_tagged |=> !tx_remove_tag)
      else $error("Tag removed from untagged frame");
   a_priority_cap: assert property (rx_taken |=> rx_priority_out <= $past(rx_priority))
      else $error("Priority raised");
endmodule
bind switch_port_control_regs port_ctrl_checker i_checker (.*);

//--- test/host_model.sv
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
module host_model (
   input wire clk,
   input wire [15:0] reg_read_data,
   input wire reg_read_valid,
   output logic [7:0] reg_address = 8'h00,
   output logic reg_write = 1'b0,
   output logic reg_read = 1'b0,
   output logic [1:0] reg_byte_enable = 2'h3,
   output logic [15:0] reg_write_data = 16'h0000
);
   // Entered at a rising edge; a read returns valid and data
   task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [16:0] q);
      reg_byte_enable <= be;
      reg_address <= a;
      reg_write_data <= d;
      reg_write <= wr;
      reg_read <= !wr;
      @(posedge clk);
      // Released lines turn over so stale values are never trusted
      reg_byte_enable <= ~be;
      reg_address <= ~a;
      reg_write_data <= ~d;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      #1 q = {reg_read_valid, reg_read_data};
      @(posedge clk);
   endtask
endmodule

//--- test/switch_port_control_regs_bench.sv
// Self-checking bench for the port 1 control register bank
`timescale 1ns/1ps
module switch_port_control_regs_bench;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, autoneg_flow_control = 1'b0;
   logic rx_frame_valid = 1'b0, tx_frame_valid = 1'b0;
   logic [36:0] rxd = '0, r;
   logic [17:0] txd = '0, t;
   logic reg_write, reg_read, reg_read_valid, flow_control_enable, back_pressure_enable;
   logic sniffer_port, rx_result_valid, rx_accept, rx_learn, rx_monitor, rx_rate_counted;
   logic tx_result_valid, tx_allowed, tx_insert_tag, tx_remove_tag, tx_monitor;
   logic [1:0] reg_byte_enable, tx_queue;
   logic [2:0] rx_priority_out, rx_forward_ports;
   logic [7:0] reg_address;
   logic [11:0] rx_effective_vid, rx_rate_bytes, tx_rate_bytes;
   logic [15:0] reg_write_data, reg_read_data, tx_tag, d, ln;
   logic [1:0] be;
   logic [16:0] q;
   logic [15:0] sh [4] = '{16'h0000, 16'h0607, 16'h0001, 16'h0000};
   logic [15:0] msk [4] = '{16'h0007, 16'h7fef, 16'hffff, 16'h000f};
   logic [7:0] ofs [4] = '{8'h6c, 8'h6e, 8'h70, 8'h72};
   logic [36:0] rq [$];
   logic [17:0] tq [$];
   int n_errors = 0, check_count = 0;
   host_model i_host (.*);
   switch_port_control_regs i_dut (.*, .rx_tagged(rxd[36]), .rx_vid(rxd[35:24]),
      .rx_priority(rxd[23:21]), .rx_vlan_members(rxd[20:18]), .rx_destination_ports(rxd[17:15]),
      .rx_broadcast(rxd[14]), .rx_multicast(rxd[13]), .rx_flooded(rxd[12]),
      .rx_length(rxd[11:0]), .tx_was_tagged(txd[17]), .tx_class(txd[16:15]),
      .tx_source_port(txd[14:12]), .tx_length(txd[11:0]));
   function automatic logic [11:0] bytes(logic [11:0] len);
      return len + (sh[3][1] ? 12'h00c : 12'h000) + (sh[3][0] ? 12'h008 : 12'h000);
   endfunction
   function automatic logic [33:0] rx_exp(logic [36:0] x);
      logic [11:0] v;
      logic a, n;
      logic [2:0] p;
      v = (!x[36] || x[35:24] == 12'h000) ? sh[2][11:0] : x[35:24];
      a = sh[1][9] && !(sh[1][14] && !x[18]) && !(sh[1][13] && x[36] && x[35:24] != sh[2][11:0]);
      p = (sh[1][3] && x[23:21] > sh[2][15:13]) ? sh[2][15:13] : x[23:21];
      n = sh[3][3] ? (x[14] || (!sh[3][2] && x[13])) : (!sh[3][2] || |x[14:12]);
      return {a, a && !sh[1][8], a && sh[1][6], v, p, a ? x[17:15] & sh[1][2:0] : 3'h0, n,
         bytes(x[11:0])};
   endfunction
   function automatic logic [33:0] tx_exp(logic [17:0] x);
      return {sh[1][10] && |(x[14:12] & sh[1][2:0]), sh[0][2] && !x[17], sh[0][1] && x[17],
         sh[2], sh[0][0] ? x[16:15] : 2'h0, sh[1][10] && sh[1][5], bytes(x[11:0])};
   endfunction
   task check(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever #25 clk = ~clk;
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end
   always @(posedge clk) begin
      if (rx_result_valid === 1'b1) begin
         check({rx_accept, rx_learn, rx_monitor, rx_effective_vid, rx_priority_out,
            rx_forward_ports, rx_rate_counted, rx_rate_bytes},
      rx_exp(rq.pop_front()));
         check({flow_control_enable, back_pressure_enable, sniffer_port},
            {sh[1][12] | autoneg_flow_control, sh[1][11], sh[1][7]});
      end
      if (tx_result_valid === 1'b1) check({tx_allowed, tx_insert_tag, tx_remove_tag, tx_tag,
         tx_queue, tx_monitor, tx_rate_bytes}, tx_exp(tq.pop_front()));
   end
   initial begin
      void'($urandom(71398));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         i_host.access(1'b0, i < 4 ? ofs[i] : 8'h74, 16'h0000, 2'h3, q);
         check(q, i < 4 ? {1'b1, sh[i]} : 17'h10000);
      end
      for (int n = 0; n < 100; n++) begin
         for (int i = 0; i < 4; i++) begin
            d = n == 0 ? 16'hffff : 16'($urandom);
            be = n == 0 ? 2'h3 : 2'($urandom);
            if (i == 1 && n % 4 != 0) begin
               d[10:9] = 2'h3;
               be[1] = 1'b1;
            end
            i_host.access(1'b1, ofs[i], d, be, q);
            ln = {{8{be[1]}}, {8{be[0]}}};
            sh[i] = ((sh[i] & ~ln) | (d & ln)) & msk[i];
            i_host.access(1'b0, ofs[i], 16'h0000, 2'h3, q);
            check(q, {1'b1, sh[i]});
         end
         // A write while the clock enable is low must not land
         ce <= 1'b0;
         i_host.access(1'b1, ofs[n % 4], ~sh[n % 4], 2'h3, q);
         ce <= 1'b1;
         i_host.access(1'b0, ofs[n % 4], 16'h0000, 2'h3, q);
         check(q, {1'b1, sh[n % 4]});
         autoneg_flow_control <= 1'($urandom);
         for (int k = 0; k < 8; k++) begin
            r = 37'({$urandom, $urandom});
            if (k % 3 == 0) r[35:24] = k == 3 ? 12'h000 : sh[2][11:0];
            t = 18'($urandom);
            t[14:12] = 3'h1 << (k % 3);
            rxd <= r;
            txd <= t;
            rq.push_back(r);
            tq.push_back(t);
            rx_frame_valid <= 1'b1;
            tx_frame_valid <= 1'b1;
            @(posedge clk);
         end
         rx_frame_valid <= 1'b0;
         tx_frame_valid <= 1'b0;
         repeat (2) @(posedge clk);
      end
      stop_test();
   end
endmodule
